/* testbench/ssp_strap_model.sv */
// Strap pin and configuration loader model
`timescale 1ns/1ns
module ssp_strap_model (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [5:0] i_pin_level,
  input wire logic [5:0] i_pin_drive,
  input wire logic [5:0] i_ovr_value,
  input wire logic [5:0] i_ovr_use,
  input wire logic [7:0] i_done_wait,
  output logic [5:0] o_strap_pins,
  output logic [5:0] o_strap_driven,
  output logic [5:0] o_loader_straps,
  output logic [5:0] o_loader_valid,
  output logic o_loader_done
);
  logic [7:0] cnt;
  logic [5:0] junk;
  // Loader finishes after a settable wait; junk exposes unused lines
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 8'h00;
      junk <= 6'h15;
      o_loader_done <= 1'b0;
    end else begin
      junk <= ~junk;
      if (cnt != i_done_wait) cnt <= cnt + 8'h01;
      o_loader_done <= (cnt == i_done_wait);
    end
  end
  // Undriven pins and unused slots wander, so they must be ignored
  assign o_strap_pins = (i_pin_drive & i_pin_level) | (~i_pin_drive & junk);
  assign o_strap_driven = i_pin_drive;
  assign o_loader_straps = (i_ovr_use & i_ovr_value) | (~i_ovr_use & ~junk);
  assign o_loader_valid = i_ovr_use;
endmodule

/* testbench/ssp_top_properties.sv */
// Port-level checks for the soft strap loader
`timescale 1ns/1ns
module ssp_top_properties (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [5:0] i_strap_pins,
  input wire logic [5:0] i_strap_driven,
  input wire logic [5:0] i_loader_straps,
  input wire logic [5:0] i_loader_valid,
  input wire logic i_loader_done,
  input wire logic i_port0_an_fail,
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic o_defaults_loaded,
  input wire logic o_port0_speed_100,
  input wire logic o_port2_speed_100,
  input wire logic o_port2_full_duplex
);
  // Effective straps; valid only while strap inputs hold after load
  wire logic [5:0] eff = (i_loader_valid & i_loader_straps) |
    (~i_loader_valid & ((i_strap_driven & i_strap_pins) |
    (~i_strap_driven & ssp_pkg::STRAP_DEFAULT)));
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Read data slot of a given register once running
  sequence rd_of(logic [2:0] idx);
    $past(i_rd) && $past(i_addr) == idx && o_defaults_loaded;
  endsequence
  loaded_hold_a: assert property (
    o_defaults_loaded |=> o_defaults_loaded) else $error("loaded fell");
  load_cause_a: assert property (
    $rose(o_defaults_loaded) |-> $past(i_loader_done, 3))
    else $error("loaded without loader done");
  load_bound_a: assert property (
    $rose(i_loader_done) |-> ##[1:20] o_defaults_loaded)
    else $error("load too slow");
  port2_init_a: assert property (
    $rose(o_defaults_loaded) |-> o_port2_speed_100 == eff[0] &&
    o_port2_full_duplex == eff[1]) else $error("port 2 defaults wrong");
  basic_write_a: assert property (
    i_wr && i_addr == ssp_pkg::REG_BASIC && o_defaults_loaded |->
    ##2 o_port2_speed_100 == $past(i_wdata[13], 2) &&
    o_port2_full_duplex == $past(i_wdata[8], 2))
    else $error("basic write not applied");
  fallback_a: assert property (
    (o_defaults_loaded && i_port0_an_fail) [*3] |=>
    o_port0_speed_100 == eff[5]) else $error("port 0 fallback wrong");
  flow_dflt_a: assert property (
    rd_of(ssp_pkg::REG_FLOWCTL) |->
    o_rdata[3:0] == {eff[4], eff[2], eff[3], eff[3]})
    else $error("flow control default wrong");
  partner_dflt_a: assert property (
    rd_of(ssp_pkg::REG_PARTNER) |->
    o_rdata[8:5] == {eff[5], eff[5], ~eff[5], ~eff[5]})
    else $error("partner ability default wrong");
  adv_pause_a: assert property (
    rd_of(ssp_pkg::REG_ADV) |->
    o_rdata[11:10] == (eff[4] ? 2'b00 : {2{eff[3]}}))
    else $error("pause advert default wrong");
  load_c: cover property ($rose(o_defaults_loaded));
  fail_c: cover property (o_defaults_loaded && i_port0_an_fail);
  write_c: cover property (i_wr && o_defaults_loaded);
endmodule

bind ssp_top ssp_top_properties chk (.*);

/* testbench/tb_top.sv */
// Self-checking bench for the soft strap loader
`timescale 1ns/1ns
module tb_top;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [5:0] lv = 6'h00, dv = 6'h00, ov = 6'h00, uv = 6'h00;
  logic [7:0] dw = 8'h00;
  logic i_port0_an_fail = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [5:0] i_strap_pins, i_strap_driven, i_loader_straps, i_loader_valid;
  logic i_loader_done, o_defaults_loaded, o_port0_speed_100;
  logic o_port2_speed_100, o_port2_full_duplex;
  logic [15:0] o_rdata, seen;
  logic [5:0] eff;
  int bad_count = 0;
  int total_checks = 0;

  always #20 i_clk_sys = ~i_clk_sys;

  ssp_top uut (.*);
  ssp_strap_model model (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_pin_level(lv), .i_pin_drive(dv), .i_ovr_value(ov), .i_ovr_use(uv),
    .i_done_wait(dw), .o_strap_pins(i_strap_pins),
    .o_strap_driven(i_strap_driven), .o_loader_straps(i_loader_straps),
    .o_loader_valid(i_loader_valid), .o_loader_done(i_loader_done));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 seen = o_rdata;
  endtask

  function automatic logic [15:0] want(input logic [2:0] a, input logic f);
    case (a)
      ssp_pkg::REG_BASIC: want = ssp_pkg::BASIC_BASE |
        {2'h0, eff[0], 4'h0, eff[1], 8'h00};
      ssp_pkg::REG_ADV: want = ssp_pkg::ADV_BASE |
        {9'h000, eff[1] & ~eff[0], ~eff[0], 5'h00} |
        {4'h0, (eff[4] ? 2'b00 : {2{eff[3]}}), 10'h000};
      ssp_pkg::REG_MODES: want = {9'h000, eff[0], eff[1], 5'h00};
      ssp_pkg::REG_FLOWCTL: want = {12'h000, eff[4], eff[2], eff[3], eff[3]};
      ssp_pkg::REG_PARTNER: want = ssp_pkg::PARTNER_BASE |
        {7'h00, eff[5], eff[5], ~eff[5], ~eff[5], 5'h00};
      ssp_pkg::REG_STRAPS: want = {10'h000, eff};
      ssp_pkg::REG_OVERRIDE: want = {10'h000, uv};
      ssp_pkg::REG_STATUS: want = {13'h0000, eff[5], f, 1'b1};
      default: want = 16'h0000;
    endcase
  endfunction

  // Reset, an early write that must be dropped, then wait for load
  task automatic boot(input logic [5:0] l, d, o, u, input logic [7:0] w);
    int n;
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    lv <= l;
    dv <= d;
    ov <= o;
    uv <= u;
    dw <= w;
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    eff = (u & o) | (~u & ((d & l) | (~d & ssp_pkg::STRAP_DEFAULT)));
    wr(ssp_pkg::REG_BASIC, 16'h0000);
    n = 0;
    while (o_defaults_loaded !== 1'b1 && n < 200) begin
      @(posedge i_clk_sys);
      n++;
    end
    check({15'h0, o_defaults_loaded}, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      rd(3'(i));
      check(seen, want(3'(i), 1'b0));
    end
    check({14'h0, o_port2_speed_100, o_port2_full_duplex},
      {14'h0, eff[0], eff[1]});
  endtask

  task automatic t_write;
    boot(6'h00, 6'h00, 6'h00, 6'h00, 8'h02);
    wr(ssp_pkg::REG_BASIC, 16'h2100);
    rd(ssp_pkg::REG_BASIC);
    check(seen, 16'h2100);
    check({14'h0, o_port2_speed_100, o_port2_full_duplex}, 16'h0003);
    wr(ssp_pkg::REG_BASIC, 16'h0000);
    wr(ssp_pkg::REG_STATUS, 16'hffff);
    rd(ssp_pkg::REG_STATUS);
    check(seen, want(ssp_pkg::REG_STATUS, 1'b0));
    check({14'h0, o_port2_speed_100, o_port2_full_duplex}, 16'h0000);
  endtask

  task automatic t_fallback(input logic [5:0] l);
    boot(l, 6'h20, 6'h00, 6'h00, 8'h03);
    @(posedge i_clk_sys);
    i_port0_an_fail <= 1'b1;
    rd(ssp_pkg::REG_STATUS);
    repeat (4) @(posedge i_clk_sys);
    rd(ssp_pkg::REG_STATUS);
    check(seen, want(ssp_pkg::REG_STATUS, 1'b1));
    check({15'h0, o_port0_speed_100}, {15'h0, eff[5]});
    @(posedge i_clk_sys);
    i_port0_an_fail <= 1'b0;
  endtask

  initial begin
    #(40 * 20000);
    bad_count++;
    end_of_test;
  end

  // Defaults, pins with forced pause, slow loader override, writes
  initial begin
    boot(6'h00, 6'h00, 6'h00, 6'h00, 8'h00);
    boot(6'h18, 6'h3f, 6'h00, 6'h00, 8'h05);
    boot(6'h00, 6'h3f, 6'h0a, 6'h3f, 8'h28);
    t_write;
    t_fallback(6'h00);
    t_fallback(6'h20);
    end_of_test;
  end
endmodule

/* verilog/ssp_pkg.sv */
// Constants for the soft strap default loader
package ssp_pkg;
  // Strap vector bit positions
  localparam int STRAP_W = 6;
  localparam int ST_SPEED2 = 0;
  localparam int ST_DUPLEX2 = 1;
  localparam int ST_BP2 = 2;
  localparam int ST_FDFC2 = 3;
  localparam int ST_MANFC2 = 4;
  localparam int ST_SPEED0 = 5;
  // Strap defaults when undriven
  localparam logic [5:0] STRAP_DEFAULT = 6'h2f;
  // Register bank indices
  localparam logic [2:0] REG_BASIC = 3'h0;
  localparam logic [2:0] REG_ADV = 3'h1;
  localparam logic [2:0] REG_MODES = 3'h2;
  localparam logic [2:0] REG_FLOWCTL = 3'h3;
  localparam logic [2:0] REG_PARTNER = 3'h4;
  localparam logic [2:0] REG_STRAPS = 3'h5;
  localparam logic [2:0] REG_OVERRIDE = 3'h6;
  localparam logic [2:0] REG_STATUS = 3'h7;
  localparam int NREG = 8;
  // Basic control fields
  localparam int BC_DUPLEX = 8;
  localparam int BC_ANEN = 12;
  localparam int BC_SPEED_LSB = 13;
  // Advertisement fields
  localparam int ADV_10HD = 5;
  localparam int ADV_10FD = 6;
  localparam int ADV_100HD = 7;
  localparam int ADV_100FD = 8;
  localparam int ADV_SYM = 10;
  localparam int ADV_ASYM = 11;
  // Special modes field
  localparam int MODE_LSB = 5;
  // Flow control fields
  localparam int FC_RX = 0;
  localparam int FC_TX = 1;
  localparam int FC_BP = 2;
  localparam int FC_MAN = 3;
  // Status fields
  localparam int STS_LOADED = 0;
  localparam int STS_AN_FAIL = 1;
  localparam int STS_SPEED0 = 2;
  // Fixed base values of the strap-driven registers
  localparam logic [15:0] BASIC_BASE = 16'h1000;
  localparam logic [15:0] ADV_BASE = 16'h0181;
  localparam logic [15:0] MODES_BASE = 16'h0000;
  localparam logic [15:0] PARTNER_BASE = 16'h0001;
  typedef enum logic [1:0] {SSP_IDLE, SSP_LOAD, SSP_RUN} ssp_state_t;
endpackage

/* verilog/ssp_reg_if.sv */
// Register bank write and read carrier
`timescale 1ns/1ns
interface ssp_reg_if;
  logic we;
  logic [2:0] waddr;
  logic [15:0] wdata;
  logic re;
  logic [2:0] raddr;
  logic [15:0] rdata;
  modport ctl (output we, waddr, wdata, re, raddr, input rdata);
  modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface

/* verilog/ssp_regbank.sv */
// Small register memory with registered read data
`timescale 1ns/1ns
module ssp_regbank #(
  parameter int DEPTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  ssp_reg_if.mem bus
);
  logic [15:0] mem [DEPTH];
  logic [15:0] rdata;

  // Contents come only from the controller, so no reset needed here
  always_ff @(posedge i_clk_sys) begin
    if (bus.we) begin
      mem[bus.waddr] <= bus.wdata;
    end
  end

  // Read data registered
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rdata <= 16'h0000;
    end else if (bus.re) begin
      rdata <= mem[bus.raddr];
    end
  end

  assign bus.rdata = rdata;
endmodule

/* verilog/ssp_top.sv */
// Soft strap loader turning straps into port register defaults
//
// Notes on behaviour
// - Port2 speed strap defaults one, sets speed
// - Speed strap feeds 10M advert bits, mode
// - Duplex strap defaults one, feeds duplex bits
// - Backpressure strap defaults one, sets enable
// - Pause strap defaults one, sets tx/rx
// - Pause strap may set asymmetric pause advert
// - Forced pause strap defaults zero, sets select
// - Forced pause strap clears both pause adverts
// - Port0 speed strap sets four partner bits
// - Port0 falls back to strapped speed
// - Loader values may replace soft straps
`timescale 1ns/1ns
module ssp_top (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [5:0] i_strap_pins,
  input wire logic [5:0] i_strap_driven,
  input wire logic [5:0] i_loader_straps,
  input wire logic [5:0] i_loader_valid,
  input wire logic i_loader_done,
  input wire logic i_port0_an_fail,
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_defaults_loaded,
  output logic o_port0_speed_100,
  output logic o_port2_speed_100,
  output logic o_port2_full_duplex
);
  // Five default words live in the bank; straps, mask, status are local
  ssp_reg_if rif ();

  ssp_regbank #(
    .DEPTH(ssp_pkg::NREG)
  ) u_bank (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .bus(rif.mem)
  );

  // Pin and loader inputs come from outside the clock domain.
  // Each line gets its own pair of flops; the loader must set its words
  // a cycle before raising done, or a mix of old and new is captured.
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic [5:0] drv_s1;
  logic [5:0] drv_s2;
  logic [5:0] ldv_s1;
  logic [5:0] ldv_s2;
  logic [5:0] lds_s1;
  logic [5:0] lds_s2;
  logic done_s1;
  logic done_s2;
  logic anf_s1;
  logic anf_s2;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
      drv_s1 <= 6'h00;
      drv_s2 <= 6'h00;
    end else begin
      pin_s1 <= i_strap_pins;
      pin_s2 <= pin_s1;
      drv_s1 <= i_strap_driven;
      drv_s2 <= drv_s1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      lds_s1 <= 6'h00;
      lds_s2 <= 6'h00;
      ldv_s1 <= 6'h00;
      ldv_s2 <= 6'h00;
    end else begin
      lds_s1 <= i_loader_straps;
      lds_s2 <= lds_s1;
      ldv_s1 <= i_loader_valid;
      ldv_s2 <= ldv_s1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      anf_s1 <= 1'b0;
      anf_s2 <= 1'b0;
    end else begin
      done_s1 <= i_loader_done;
      done_s2 <= done_s1;
      anf_s1 <= i_port0_an_fail;
      anf_s2 <= anf_s1;
    end
  end

  // Undriven pins fall back to their strap defaults, per bit
  // Straps are static after power-up, so no handshake is needed
  logic [5:0] pin_value;
  logic [5:0] eff_strap;
  genvar g;
  generate
    for (g = 0; g < ssp_pkg::STRAP_W; g++) begin : g_strap
      assign pin_value[g] = drv_s2[g] ? pin_s2[g] :
        ssp_pkg::STRAP_DEFAULT[g];
      assign eff_strap[g] = ldv_s2[g] ? lds_s2[g] : pin_value[g];
    end
  endgenerate

  // Straps captured when the loader is done, so overrides land first
  logic [5:0] strap_q;
  logic [5:0] ovr_q;
  ssp_pkg::ssp_state_t state;
  ssp_pkg::ssp_state_t next_state;
  logic [2:0] load_idx;
  logic [2:0] next_load_idx;

  // Load sequencer: idle until done, then one bank write per cycle
  // through basic control up to partner ability, five words in all
  always_comb begin
    next_state = state;
    next_load_idx = load_idx;
    case (state)
      ssp_pkg::SSP_IDLE: begin
        // Pins alone never start a load; the loader must finish
        if (done_s2) begin
          next_state = ssp_pkg::SSP_LOAD;
          next_load_idx = ssp_pkg::REG_BASIC;
        end
      end
      ssp_pkg::SSP_LOAD: begin
        next_load_idx = load_idx + 3'h1;
        if (load_idx == ssp_pkg::REG_PARTNER) begin
          next_state = ssp_pkg::SSP_RUN;
        end
      end
      ssp_pkg::SSP_RUN: begin
        // Held until the next reset
        next_state = ssp_pkg::SSP_RUN;
      end
      default: begin
        // A stray encoding restarts the sequence cleanly
        next_state = ssp_pkg::SSP_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state <= ssp_pkg::SSP_IDLE;
      load_idx <= 3'h0;
    end else begin
      state <= next_state;
      load_idx <= next_load_idx;
    end
  end

  // Fires on one edge only: the first with done seen high
  wire capture = (state == ssp_pkg::SSP_IDLE) && done_s2;

  // Latch strap values once; later pin wiggles do not disturb registers
  // The mask is kept so software can tell loader values from pins
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      strap_q <= 6'h00;
      ovr_q <= 6'h00;
    end else if (capture) begin
      strap_q <= eff_strap;
      ovr_q <= ldv_s2;
    end
  end

  // Named strap bits
  wire s_speed2 = strap_q[ssp_pkg::ST_SPEED2];
  wire s_duplex2 = strap_q[ssp_pkg::ST_DUPLEX2];
  wire s_bp2 = strap_q[ssp_pkg::ST_BP2];
  wire s_fdfc2 = strap_q[ssp_pkg::ST_FDFC2];
  wire s_manfc2 = strap_q[ssp_pkg::ST_MANFC2];
  wire s_speed0 = strap_q[ssp_pkg::ST_SPEED0];

  // Basic control default: speed low bit and duplex
  // Autoneg enable comes from the base word; no strap here drives it
  logic [15:0] basic_dflt;
  always_comb begin
    basic_dflt = ssp_pkg::BASIC_BASE;
    basic_dflt[ssp_pkg::BC_SPEED_LSB] = s_speed2;
    basic_dflt[ssp_pkg::BC_DUPLEX] = s_duplex2;
  end

  // Advertisement default; 10M only offered when strapped down to 10M
  logic [15:0] adv_dflt;
  always_comb begin
    adv_dflt = ssp_pkg::ADV_BASE;
    adv_dflt[ssp_pkg::ADV_10HD] = !s_speed2;
    adv_dflt[ssp_pkg::ADV_10FD] = !s_speed2 && s_duplex2;
    // Forced pause: no symmetric and no asymmetric pause advert
    if (s_manfc2) begin
      adv_dflt[ssp_pkg::ADV_SYM] = 1'b0;
      adv_dflt[ssp_pkg::ADV_ASYM] = 1'b0;
    end else begin
      adv_dflt[ssp_pkg::ADV_SYM] = s_fdfc2;
      adv_dflt[ssp_pkg::ADV_ASYM] = s_fdfc2;
    end
  end

  // Mode field: 100FD, 100HD, 10FD or 10HD forced choice
  // Top mode bit stays clear; no strap selects the all-capable mode
  logic [15:0] modes_dflt;
  always_comb begin
    modes_dflt = ssp_pkg::MODES_BASE;
    modes_dflt[ssp_pkg::MODE_LSB +: 3] = {1'b0, s_speed2, s_duplex2};
  end

  // Flow control default; rx and tx pause share one strap
  // Backpressure only matters in half duplex but is loaded regardless
  logic [15:0] fc_dflt;
  always_comb begin
    fc_dflt = 16'h0000;
    fc_dflt[ssp_pkg::FC_BP] = s_bp2;
    fc_dflt[ssp_pkg::FC_TX] = s_fdfc2;
    fc_dflt[ssp_pkg::FC_RX] = s_fdfc2;
    fc_dflt[ssp_pkg::FC_MAN] = s_manfc2;
  end

  // Emulated PHY partner abilities follow port 0 speed
  // The partner claims only the strapped rate, so autoneg lands on it
  logic [15:0] partner_dflt;
  always_comb begin
    partner_dflt = ssp_pkg::PARTNER_BASE;
    partner_dflt[ssp_pkg::ADV_100FD] = s_speed0;
    partner_dflt[ssp_pkg::ADV_100HD] = s_speed0;
    partner_dflt[ssp_pkg::ADV_10FD] = !s_speed0;
    partner_dflt[ssp_pkg::ADV_10HD] = !s_speed0;
  end

  // Default word for the register being loaded
  // Indices above the partner word never reach here while loading
  logic [15:0] load_word;
  always_comb begin
    case (load_idx)
      ssp_pkg::REG_BASIC: load_word = basic_dflt;
      ssp_pkg::REG_ADV: load_word = adv_dflt;
      ssp_pkg::REG_MODES: load_word = modes_dflt;
      ssp_pkg::REG_FLOWCTL: load_word = fc_dflt;
      ssp_pkg::REG_PARTNER: load_word = partner_dflt;
      default: load_word = 16'h0000;
    endcase
  end

  // Software decode; writes refused until defaults are in place
  // Early writes would be lost anyway, as the sequencer overwrites them
  // Writes to the local read-only words fall through and are dropped
  wire loading = (state == ssp_pkg::SSP_LOAD);
  wire running = (state == ssp_pkg::SSP_RUN);
  wire sw_wr_mem = i_wr && running && (i_addr <= ssp_pkg::REG_PARTNER);
  wire rd_mem = i_rd && (i_addr <= ssp_pkg::REG_PARTNER);

  // Loader owns the write port while loading, software after
  // Software is refused while loading, so the writers never collide
  assign rif.we = loading || sw_wr_mem;
  assign rif.waddr = loading ? load_idx : i_addr;
  assign rif.wdata = loading ? load_word : i_wdata;
  assign rif.re = rd_mem;
  assign rif.raddr = i_addr;

  // Shadow copies of live control bits for the outputs
  // Kept beside the bank so the port outputs need no second read port
  logic [15:0] basic_live;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      basic_live <= ssp_pkg::BASIC_BASE;
    end else if (rif.we && rif.waddr == ssp_pkg::REG_BASIC) begin
      basic_live <= rif.wdata;
    end
  end

  // Local register read path, muxed with bank data one cycle later
  logic rd_local;
  logic rd_bank;
  logic [15:0] local_q;
  // Status fields placed at their package positions
  logic [15:0] status_word;
  always_comb begin
    status_word = 16'h0000;
    status_word[ssp_pkg::STS_LOADED] = running;
    status_word[ssp_pkg::STS_AN_FAIL] = anf_s2;
    status_word[ssp_pkg::STS_SPEED0] = s_speed0;
  end
  logic [15:0] local_word;
  always_comb begin
    case (i_addr)
      ssp_pkg::REG_STRAPS: local_word = {10'h000, strap_q};
      ssp_pkg::REG_OVERRIDE: local_word = {10'h000, ovr_q};
      ssp_pkg::REG_STATUS: local_word = status_word;
      default: local_word = 16'h0000;
    endcase
  end

  // Local word captured every cycle, used only after a local read
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rd_bank <= 1'b0;
      rd_local <= 1'b0;
      local_q <= 16'h0000;
    end else begin
      rd_bank <= rd_mem;
      rd_local <= i_rd && !rd_mem;
      local_q <= local_word;
    end
  end

  // Combined read data; zero when no read happened
  // A mux of registered words, not a flop of its own: one more stage
  // would push the data past the cycle after the strobe
  always_comb begin
    if (rd_bank) begin
      o_rdata = rif.rdata;
    end else if (rd_local) begin
      o_rdata = local_q;
    end else begin
      o_rdata = 16'h0000;
    end
  end

  // Port 0 takes the strapped speed only while autoneg reports failure,
  // and keeps the last value once the failure clears
  wire port0_speed_next = anf_s2 ? s_speed0 : o_port0_speed_100;

  // Status outputs; port 0 speed falls back to strap on failure
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_defaults_loaded <= 1'b0;
      o_port0_speed_100 <= 1'b0;
      o_port2_speed_100 <= 1'b0;
      o_port2_full_duplex <= 1'b0;
    end else begin
      o_defaults_loaded <= running;
      o_port0_speed_100 <= port0_speed_next;
      o_port2_speed_100 <= basic_live[ssp_pkg::BC_SPEED_LSB];
      o_port2_full_duplex <= basic_live[ssp_pkg::BC_DUPLEX];
    end
  end
endmodule
